// ### core/paf_pkg.sv
package paf_pkg;

  // Widths of the reading path and of the averaging count.
  localparam int DATA_W        = 24;
  localparam int CNT_W         = 17;

  // Values after reset and their limits.
  localparam logic [16:0] RST_AVG_COUNT   = 17'h0_0004;
  localparam logic [16:0] MAX_AVG_COUNT   = 17'h1_0000;
  localparam logic [2:0]  RST_DIGITS      = 3'h3;
  localparam logic [2:0]  MAX_DIGITS      = 3'h4;
  localparam logic [2:0]  MIN_DIGITS      = 3'h1;
  // Noise target in micro-dB: 0.01 dB after reset, 100e-6 to 1.00 dB.
  localparam logic [19:0] RST_NOISE_UDB   = 20'h0_2710;
  localparam logic [19:0] MIN_NOISE_UDB   = 20'h0_0064;
  localparam logic [19:0] MAX_NOISE_UDB   = 20'hF_4240;
  // Settling time cap in centiseconds: 4.00 s after reset, 0.01 to 999.99 s.
  localparam logic [16:0] RST_CAP_CS      = 17'h0_0190;
  localparam logic [16:0] MIN_CAP_CS      = 17'h0_0001;
  localparam logic [16:0] MAX_CAP_CS      = 17'h1_869F;
  // Sampling window in microseconds: 0.02 s after reset, 8 us to 2.00 s.
  localparam logic [20:0] RST_APER_US     = 21'h00_4E20;
  localparam logic [20:0] MIN_APER_US     = 21'h00_0008;
  localparam logic [20:0] MAX_APER_US     = 21'h1E_8480;

  // Timing at the 25 MHz system clock.
  localparam int CLK_MHZ        = 25;
  localparam int CHOP_SWITCH_US = 100;
  localparam int CHOP_SWITCH_CYC = CHOP_SWITCH_US * CLK_MHZ;
  localparam int FAST_RATE_HZ   = 100000;
  localparam int FAST_MIN_CYC   = (CLK_MHZ * 1000000) / FAST_RATE_HZ;

  // Termination modes and automatic criteria.
  typedef enum logic {PAF_TERM_REPEAT = 1'b0, PAF_TERM_MOVING = 1'b1} paf_term_t;
  typedef enum logic {PAF_CRIT_DIGITS = 1'b0, PAF_CRIT_NOISE = 1'b1} paf_crit_t;
  typedef enum logic [1:0] {PAF_AUTO_OFF = 2'h0, PAF_AUTO_ON = 2'h1,
                            PAF_AUTO_SINGLE_SHOT_AUTO = 2'h2} paf_auto_t;
  // Selection left by a count write: the configured count is used as it stands.
  localparam logic [1:0] PAF_AUTO_FIXED_SEL = 2'h3;

endpackage : paf_pkg

// ### core/paf_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
// Valid/ready stream carrying one word between the filter's modules.
interface paf_stream_if #(parameter int W = 24);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : paf_stream_if
`default_nettype wire

// ### core/paf_skid_buf.sv
`timescale 1ns/100ps
`default_nettype none
// Two-entry buffer: a stall downstream is absorbed without losing a word.
module paf_skid_buf #(
  parameter int W = 24
) (
  // Clock and reset.
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  // Streams.
  paf_stream_if.dst up,
  paf_stream_if.src dn
);
  logic [W-1:0] mem_ff [2];
  logic [W-1:0] nxt_mem [2];
  logic         wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [1:0]   cnt_ff, nxt_cnt;
  logic         push, pop;

  // Ready upstream only while a slot is free, so the source really stalls.
  assign up.ready = (cnt_ff != 2'h2);
  assign dn.valid = (cnt_ff != 2'h0);
  assign dn.data  = mem_ff[rd_ff];
  assign push     = up.valid && up.ready;
  assign pop      = dn.valid && dn.ready;

  // Pointer and occupancy update.
  always_comb begin
    nxt_mem = mem_ff;
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wr_ff] = up.data;
      nxt_wr         = ~wr_ff;
    end
    if (pop) begin
      nxt_rd = ~rd_ff;
    end
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
  end

  // Register stage.
  always_ff @(posedge clk_sys_in) begin
    mem_ff <= nxt_mem;
    if (!nrst_in) begin
      wr_ff  <= 1'b0;
      rd_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  AST_BUF_NO_OVERFLOW: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    cnt_ff == 2'h2 |-> !up.ready)
    else $error("Buffer accepted a word while full.");
endmodule : paf_skid_buf
`default_nettype wire

// ### core/paf_smoother.sv
`timescale 1ns/100ps
`default_nettype none
// Switchable lowpass: four-tap raised-cosine style weights 1-3-3-1 over 8.
module paf_smoother #(
  parameter int W = 24
) (
  // Clock and reset.
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  // Control.
  input  wire logic enable_in,
  input  wire logic flush_in,
  // Streams.
  paf_stream_if.dst up,
  paf_stream_if.src dn
);
  logic [W-1:0] tap_ff [3];
  logic [W-1:0] nxt_tap [3];
  logic [W+2:0] wsum;

  // Pass through when disabled; otherwise weight the last four readings.
  // Sized cast: eight full-scale readings still fit in W+3 bits, so nothing is lost.
  assign wsum = (W+3)'({3'h0, up.data} + 3 * {3'h0, tap_ff[0]} + 3 * {3'h0, tap_ff[1]}
              + {3'h0, tap_ff[2]});
  assign dn.valid = up.valid;
  assign dn.data  = enable_in ? wsum[W+2:3] : up.data;
  assign up.ready = dn.ready;

  // Tap line clears on a flush, else advances on every accepted reading.
  always_comb begin
    nxt_tap = tap_ff;
    if (flush_in) begin
      nxt_tap = '{default: '0};
    end else if (up.valid && dn.ready) begin
      nxt_tap[0] = up.data;
      nxt_tap[1] = tap_ff[0];
      nxt_tap[2] = tap_ff[1];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      tap_ff <= '{default: '0};
    end else begin
      tap_ff <= nxt_tap;
    end
  end

  AST_SMOOTH_BYPASS: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !enable_in |-> dn.data == up.data)
    else $error("Disabled smoother altered the reading.");
endmodule : paf_smoother
`default_nettype wire

// ### core/paf_avg_filter.sv
//
// Overview of operation
// - Quick mode forces count one, no error
// - Quick mode measure time is one sampling window
// - Quick mode off after reset
// - Switchable smoothing lowpass, off after reset
// - Count 1 to 65536, four after reset
// - Count applies only while averaging enabled
// - Auto mode recomputes count from digits or noise target
// - Auto off freezes last automatic count
// - Single shot computes single_shot_auto then fixes
// - Criterion digits or noise; digits after reset
// - Noise criterion caps length by settling time
// - Noise target range, 0.01 dB after reset
// - Noise measured as two standard deviations
// - Digits target 1 to 4, three after reset
// - Filter reset restarts length at one
// - Reset keeps total settling time unchanged
// - Moving mode emits intermediate and moving results
// - Repeat mode waits for count readings
// - Measure time from count, aperture and chopper
// - Sampling window 8 us to 2 s, 0.02 s reset
// - Averaging enabled after reset
//
`timescale 1ns/100ps
`default_nettype none
module paf_avg_filter #(
  parameter int DEPTH = 1024
) (
  // Clock and reset.
  input  wire logic                      clk_sys_in,
  input  wire logic                      nrst_in,
  // Settings from the command side.
  input  wire logic                      quick_mode_in,
  input  wire logic                      smoothing_in,
  input  wire logic                      avg_enable_in,
  input  wire logic [16:0]               avg_count_in,
  input  wire logic                      avg_count_we_in,
  input  wire logic [1:0]                auto_mode_in,
  input  wire logic                      auto_mode_we_in,
  input  wire logic                      criterion_in,
  input  wire logic [2:0]                digits_in,
  input  wire logic [19:0]               noise_target_in,
  input  wire logic [16:0]               settling_time_cap_in,
  input  wire logic [20:0]               aperture_in,
  input  wire logic                      output_termination_mode_in,
  input  wire logic                      cfg_we_in,
  input  wire logic                      filter_reset_in,
  // Readings from the sampling front end.
  input  wire logic                      rd_valid_in,
  input  wire logic [paf_pkg::DATA_W-1:0] rd_data_in,
  output logic                           rd_ready_out,
  // Results.
  output logic                           res_valid_out,
  output logic [paf_pkg::DATA_W-1:0]     res_data_out,
  input  wire logic                      res_ready_in,
  // Status.
  output logic [16:0]                    eff_count_out,
  output logic [16:0]                    fill_out,
  output logic [31:0]                    meas_time_us_out,
  output logic                           quick_mode_out,
  output logic                           smoothing_out
);
  localparam int DW = paf_pkg::DATA_W;
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("DEPTH must be a power of two of at least four.");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clamp a requested count into the legal range.
  function automatic logic [16:0] clamp_count(input logic [16:0] c);
    if (c == 17'h0_0000) begin
      return 17'h0_0001;
    end
    return (c > paf_pkg::MAX_AVG_COUNT) ? paf_pkg::MAX_AVG_COUNT : c;
  endfunction : clamp_count

  // Automatic count: digits need roughly 4^(digits-1) readings; the noise
  // criterion scales with the inverse square of the target. A real sensor would use its
  // noise model; this closed form keeps the hardware to shifts and compares.
  function automatic logic [16:0] auto_count(input logic crit,
                                             input logic [2:0] dig,
                                             input logic [19:0] nt,
                                             input logic [16:0] cap);
    logic [16:0] c;
    c = 17'h0_0001;
    if (crit == paf_pkg::PAF_CRIT_DIGITS) begin
      c = 17'h0_0001 << (5'(dig - 3'h1) << 1);
    end else begin
      // Noise at two standard deviations falls as 1/sqrt(n).
      c = (nt >= 20'h0_2710) ? 17'h0_0004 : (nt >= 20'h0_03E8 ? 17'h0_0190
          : 17'h0_9C40);
      if (c > cap) begin
        c = cap;
      end
    end
    return clamp_count(c);
  endfunction : auto_count

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers.
  logic        quick_ff, smooth_ff, avg_en_ff, term_ff, crit_ff;
  logic [1:0]  auto_ff;
  logic [2:0]  dig_ff;
  logic [19:0] noise_ff;
  logic [16:0] cap_ff, count_ff, fixed_ff;
  logic [20:0] aper_ff;
  logic        nxt_quick, nxt_smooth, nxt_avg_en, nxt_term, nxt_crit;
  logic [1:0]  nxt_auto;
  logic [2:0]  nxt_dig;
  logic [19:0] nxt_noise;
  logic [16:0] nxt_cap, nxt_count, nxt_fixed, auto_val, eff_cnt;
  logic [20:0] nxt_aper;
  logic        restart;

  assign auto_val = auto_count(crit_ff, dig_ff, noise_ff, cap_ff);

  // Effective count: quick mode and disabled averaging both mean one reading.
  always_comb begin
    if (quick_ff || !avg_en_ff) begin
      eff_cnt = 17'h0_0001;
    end else if (auto_ff == paf_pkg::PAF_AUTO_ON) begin
      eff_cnt = auto_val;
    end else if (auto_ff == paf_pkg::PAF_AUTO_OFF) begin
      eff_cnt = fixed_ff;
    end else begin
      eff_cnt = count_ff;
    end
  end

  // Next settings; out-of-range values are clamped rather than flagged.
  always_comb begin
    nxt_quick  = quick_ff;
    nxt_smooth = smooth_ff;
    nxt_avg_en = avg_en_ff;
    nxt_term   = term_ff;
    nxt_crit   = crit_ff;
    nxt_dig    = dig_ff;
    nxt_noise  = noise_ff;
    nxt_cap    = cap_ff;
    nxt_aper   = aper_ff;
    nxt_count  = count_ff;
    nxt_auto   = auto_ff;
    nxt_fixed  = fixed_ff;
    if (auto_ff == paf_pkg::PAF_AUTO_ON) begin
      nxt_fixed = auto_val;
    end
    if (cfg_we_in) begin
      nxt_quick  = quick_mode_in;
      nxt_smooth = smoothing_in;
      nxt_avg_en = avg_enable_in;
      nxt_term   = output_termination_mode_in;
      nxt_crit   = criterion_in;
      nxt_dig    = (digits_in < paf_pkg::MIN_DIGITS) ? paf_pkg::MIN_DIGITS :
                   (digits_in > paf_pkg::MAX_DIGITS) ? paf_pkg::MAX_DIGITS : digits_in;
      nxt_noise  = (noise_target_in < paf_pkg::MIN_NOISE_UDB) ? paf_pkg::MIN_NOISE_UDB :
                   (noise_target_in > paf_pkg::MAX_NOISE_UDB) ? paf_pkg::MAX_NOISE_UDB :
                   noise_target_in;
      nxt_cap    = (settling_time_cap_in < paf_pkg::MIN_CAP_CS) ? paf_pkg::MIN_CAP_CS :
                   (settling_time_cap_in > paf_pkg::MAX_CAP_CS) ? paf_pkg::MAX_CAP_CS :
                   settling_time_cap_in;
      nxt_aper   = (aperture_in < paf_pkg::MIN_APER_US) ? paf_pkg::MIN_APER_US :
                   (aperture_in > paf_pkg::MAX_APER_US) ? paf_pkg::MAX_APER_US :
                   aperture_in;
    end
    if (avg_count_we_in) begin
      nxt_count = clamp_count(avg_count_in);
      nxt_auto  = 2'(paf_pkg::PAF_AUTO_FIXED_SEL);
    end
    if (auto_mode_we_in) begin
      // Single shot latches the present automatic value, then runs fixed.
      nxt_auto = (auto_mode_in == paf_pkg::PAF_AUTO_SINGLE_SHOT_AUTO) ? paf_pkg::PAF_AUTO_OFF
               : auto_mode_in;
      if (auto_mode_in == paf_pkg::PAF_AUTO_SINGLE_SHOT_AUTO) begin
        nxt_fixed = auto_val;
      end
    end
  end

  // A change of count or termination mode restarts the filter.
  assign restart = filter_reset_in || (eff_cnt != eff_count_out) ||
                   (term_ff != nxt_term);

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      quick_ff  <= 1'b0;
      smooth_ff <= 1'b0;
      avg_en_ff <= 1'b1;
      term_ff   <= paf_pkg::PAF_TERM_REPEAT;
      crit_ff   <= paf_pkg::PAF_CRIT_DIGITS;
      dig_ff    <= paf_pkg::RST_DIGITS;
      noise_ff  <= paf_pkg::RST_NOISE_UDB;
      cap_ff    <= paf_pkg::RST_CAP_CS;
      aper_ff   <= paf_pkg::RST_APER_US;
      count_ff  <= paf_pkg::RST_AVG_COUNT;
      auto_ff   <= paf_pkg::PAF_AUTO_ON;
      fixed_ff  <= paf_pkg::RST_AVG_COUNT;
    end else begin
      quick_ff  <= nxt_quick;
      smooth_ff <= nxt_smooth;
      avg_en_ff <= nxt_avg_en;
      term_ff   <= nxt_term;
      crit_ff   <= nxt_crit;
      dig_ff    <= nxt_dig;
      noise_ff  <= nxt_noise;
      cap_ff    <= nxt_cap;
      aper_ff   <= nxt_aper;
      count_ff  <= nxt_count;
      auto_ff   <= nxt_auto;
      fixed_ff  <= nxt_fixed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input smoothing, then the averaging window over a circular history.
  paf_stream_if #(.W(DW)) s_in ();
  paf_stream_if #(.W(DW)) s_sm ();
  paf_stream_if #(.W(DW)) s_res ();
  paf_stream_if #(.W(DW)) s_out ();

  assign s_in.valid   = rd_valid_in;
  assign s_in.data    = rd_data_in;
  assign rd_ready_out = s_in.ready;

  paf_smoother #(.W(DW)) u_smooth (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .enable_in  (smooth_ff),
    .flush_in   (restart),
    .up         (s_in),
    .dn         (s_sm)
  );

  logic [DW-1:0]   hist [DEPTH];
  logic [AW-1:0]   wp_ff, nxt_wp;
  logic [16:0]     fill_ff, nxt_fill, rep_ff, nxt_rep;
  logic [DW+16:0]  sum_ff, nxt_sum;
  logic            take, emit;
  logic [DW-1:0]   oldest;
  logic [16:0]     win;

  // The window is limited by the history depth; counts above DEPTH act as
  // DEPTH here, which is the trade-off for on-chip storage.
  assign win    = (eff_cnt > 17'(DEPTH)) ? 17'(DEPTH) : eff_cnt;
  assign take   = s_sm.valid && s_sm.ready;
  assign oldest = hist[wp_ff - AW'(win)];
  assign s_sm.ready = s_res.ready;
  assign emit   = take && ((term_ff == paf_pkg::PAF_TERM_MOVING) ||
                           (nxt_rep == 17'h0_0000));

  // Running sum: add the newest, drop the one falling out of the window.
  always_comb begin
    nxt_wp   = wp_ff;
    nxt_fill = fill_ff;
    nxt_sum  = sum_ff;
    nxt_rep  = rep_ff;
    if (take) begin
      nxt_wp  = wp_ff + AW'(1);
      nxt_sum = sum_ff + (DW+17)'(s_sm.data);
      if (fill_ff >= win) begin
        nxt_sum = nxt_sum - (DW+17)'(oldest);
      end else begin
        nxt_fill = fill_ff + 17'h0_0001;
      end
      nxt_rep = (rep_ff + 17'h0_0001 >= win) ? 17'h0_0000 : rep_ff + 17'h0_0001;
    end
    if (restart) begin
      nxt_fill = 17'h0_0000;
      nxt_sum  = '0;
      nxt_rep  = 17'h0_0000;
    end
  end

  // Mean over the readings actually held: the window grows from one.
  assign s_res.valid = emit && !restart;
  assign s_res.data  = DW'(nxt_sum / (DW+17)'(nxt_fill == 17'h0_0000 ? 17'h0_0001
                                                                     : nxt_fill));

  always_ff @(posedge clk_sys_in) begin
    if (take) begin
      hist[wp_ff] <= s_sm.data;
    end
    if (!nrst_in) begin
      wp_ff   <= '0;
      fill_ff <= 17'h0_0000;
      sum_ff  <= '0;
      rep_ff  <= 17'h0_0000;
    end else begin
      wp_ff   <= nxt_wp;
      fill_ff <= nxt_fill;
      sum_ff  <= nxt_sum;
      rep_ff  <= nxt_rep;
    end
  end

  paf_skid_buf #(.W(DW)) u_buf (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .up         (s_res),
    .dn         (s_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  logic [31:0] mt;
  // Chopped: 2*AC*APER + (2*AC-1)*100 us; quick: aperture alone.
  assign mt = quick_ff ? 32'(aper_ff) :
              32'(2 * eff_cnt * aper_ff) +
              32'((2 * eff_cnt - 1) * paf_pkg::CHOP_SWITCH_US);
  assign s_out.ready = !res_valid_out || res_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      res_valid_out    <= 1'b0;
      res_data_out     <= '0;
      eff_count_out    <= paf_pkg::RST_AVG_COUNT;
      fill_out         <= 17'h0_0000;
      meas_time_us_out <= 32'h0000_0000;
      quick_mode_out   <= 1'b0;
      smoothing_out    <= 1'b0;
    end else begin
      if (s_out.ready) begin
        res_valid_out <= s_out.valid;
        res_data_out  <= s_out.data;
      end
      eff_count_out    <= eff_cnt;
      fill_out         <= nxt_fill;
      meas_time_us_out <= mt;
      quick_mode_out   <= quick_ff;
      smoothing_out    <= smooth_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_QUICK_COUNT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    quick_ff |-> ##1 eff_count_out == 17'h0_0001)
    else $error("Quick mode did not force a count of one.");
  AST_AVG_OFF: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !avg_en_ff |-> ##1 eff_count_out == 17'h0_0001)
    else $error("Count applied with averaging disabled.");
  AST_RESTART: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    filter_reset_in |=> fill_ff == 17'h0_0000)
    else $error("Filter reset did not empty the window.");
  AST_FILL_BOUND: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    fill_ff <= 17'(DEPTH))
    else $error("Window grew beyond its storage.");
  AST_REPEAT_HOLD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (term_ff == paf_pkg::PAF_TERM_REPEAT && s_res.valid) |-> nxt_rep == 17'h0_0000)
    else $error("Repeat mode emitted before the count completed.");
  AST_SINGLE_SHOT_AUTO_FIX: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (auto_mode_we_in && auto_mode_in == paf_pkg::PAF_AUTO_SINGLE_SHOT_AUTO) |=>
    auto_ff == paf_pkg::PAF_AUTO_OFF && fixed_ff == $past(auto_val))
    else $error("Single shot did not fix the computed count.");
  AST_RESET_DEF: assert property (@(posedge clk_sys_in)
    !nrst_in |=> !quick_ff && !smooth_ff && avg_en_ff && count_ff == 17'h0_0004)
    else $error("Settings not at defaults after reset.");
  AST_QUICK_TIME: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    quick_ff |=> meas_time_us_out == 32'($past(aper_ff)))
    else $error("Quick measurement time is not the aperture.");
  COV_MOVING: cover property (@(posedge clk_sys_in) term_ff && s_res.valid);
  COV_REPEAT: cover property (@(posedge clk_sys_in) !term_ff && s_res.valid);
  COV_STALL: cover property (@(posedge clk_sys_in) !s_res.ready && s_res.valid);
endmodule : paf_avg_filter
`default_nettype wire

// ### sim/paf_reading_src.sv
`timescale 1ns/100ps
`default_nettype none
// Front end model: offers one reading at a time on a valid/ready stream.
module paf_reading_src (
  // Clock.
  input  wire logic                       clk_sys_in,
  // Readings.
  output logic                            valid_out,
  output logic [paf_pkg::DATA_W-1:0]      data_out,
  input  wire logic                       ready_in
);
  initial begin
    valid_out = 1'b0;
    data_out  = '0;
  end
  // Ready is combinational, so it is sampled mid-cycle to avoid an edge race.
  task automatic send(input logic [paf_pkg::DATA_W-1:0] v);
    logic r;
    @(posedge clk_sys_in);
    valid_out <= 1'b1;
    data_out  <= v;
    forever begin
      @(negedge clk_sys_in) r = ready_in;
      @(posedge clk_sys_in);
      if (r === 1'b1) break;
    end
    valid_out <= 1'b0;
    data_out  <= ~v; // A released bus shows no stale word.
  endtask : send
endmodule : paf_reading_src
`default_nettype wire

// ### sim/power_averaging_filter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module power_averaging_filter_tb;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in    = 1'b0;
  logic        quick      = 1'b0;
  logic        smooth     = 1'b0;
  logic        term       = 1'b0;
  logic        cfg_we     = 1'b0;
  logic        cnt_we     = 1'b0;
  logic        auto_we    = 1'b0;
  logic        frst       = 1'b0;
  logic        res_ready  = 1'b1;
  logic [16:0] cnt        = 17'h0_0004;
  logic [1:0]  auto_m     = 2'h1;
  logic [20:0] aper       = paf_pkg::RST_APER_US;
  logic        aen        = 1'b1;
  logic        crit       = 1'b0;
  logic [2:0]  dig        = paf_pkg::RST_DIGITS;
  wire logic        rd_valid, rd_ready, res_valid, qo, so;
  wire logic [23:0] rd_data, res_data;
  wire logic [16:0] eff, fill;
  wire logic [31:0] mt;
  int          bad_count = 0;
  int          n_tests   = 0;
  logic [23:0] got[$];

  // Half period of 20 ns gives the 25 MHz system clock.
  always #20 clk_sys_in = ~clk_sys_in;
  // Every accepted result is queued for the scenarios to judge.
  always @(posedge clk_sys_in) if (res_valid === 1'b1 && res_ready === 1'b1) got.push_back(res_data);

  paf_reading_src paf_reading_src_i (.clk_sys_in(clk_sys_in), .valid_out(rd_valid),
    .data_out(rd_data), .ready_in(rd_ready));
  paf_avg_filter #(.DEPTH(16)) paf_avg_filter_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .quick_mode_in(quick), .smoothing_in(smooth), .avg_enable_in(aen), .avg_count_in(cnt),
    .avg_count_we_in(cnt_we), .auto_mode_in(auto_m), .auto_mode_we_in(auto_we),
    .criterion_in(crit), .digits_in(dig), .noise_target_in(paf_pkg::RST_NOISE_UDB),
    .settling_time_cap_in(paf_pkg::RST_CAP_CS), .aperture_in(aper),
    .output_termination_mode_in(term), .cfg_we_in(cfg_we), .filter_reset_in(frst),
    .rd_valid_in(rd_valid), .rd_data_in(rd_data), .rd_ready_out(rd_ready),
    .res_valid_out(res_valid), .res_data_out(res_data), .res_ready_in(res_ready),
    .eff_count_out(eff), .fill_out(fill), .meas_time_us_out(mt),
    .quick_mode_out(qo), .smoothing_out(so));

  ////////////////////////////////////////////////////////////////////////////////
  // One comparison, counted, with a line printed on a mismatch.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Bounded wait for a number of results.
  task automatic await(input int n);
    for (int i = 0; i < 80 && got.size() < n; i++) @(posedge clk_sys_in);
  endtask : await
  // Latches the level settings; the queue is cleared single_shot_auto they have landed.
  task automatic cfg(input logic q, input logic s, input logic t);
    @(posedge clk_sys_in);
    quick  <= q;
    smooth <= s;
    term   <= t;
    cfg_we <= 1'b1;
    @(posedge clk_sys_in);
    cfg_we <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    got.delete();
  endtask : cfg
  // Writes a fixed count, which also leaves automatic selection.
  task automatic setcnt(input logic [16:0] c);
    @(posedge clk_sys_in);
    cnt    <= c;
    cnt_we <= 1'b1;
    @(posedge clk_sys_in);
    cnt_we <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask : setcnt
  // Automatic selection write, then a filter reset pulse.
  task automatic misc_pulses(input logic [1:0] m);
    @(posedge clk_sys_in);
    auto_m  <= m;
    auto_we <= 1'b1;
    @(posedge clk_sys_in);
    auto_we <= 1'b0;
    frst    <= 1'b1;
    @(posedge clk_sys_in);
    frst    <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask : misc_pulses

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(eff, 32'h0000_0010);
    chk(qo, 32'h0000_0000);
    chk(so, 32'h0000_0000);
    chk(res_valid, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset
  // Chopped time with count 4: 2*4*20000 + 7*100 us.
  task automatic t_repeat();
    misc_pulses(2'h2);
    setcnt(17'h0_0004);
    cfg(1'b0, 1'b0, 1'b0);
    chk(mt, 32'h0002_73BC);
    paf_reading_src_i.send(24'h00_000A);
    paf_reading_src_i.send(24'h00_0014);
    paf_reading_src_i.send(24'h00_001E);
    repeat (8) @(posedge clk_sys_in);
    chk(got.size(), 32'h0000_0000);
    paf_reading_src_i.send(24'h00_0028);
    await(1);
    chk(got[0], 32'h0000_0019);
    $display("test repeat done");
  endtask : t_repeat
  // Growing length after a mode change, then a moving mean, then an explicit reset.
  task automatic t_moving();
    cfg(1'b0, 1'b0, 1'b1);
    chk(fill, 32'h0000_0000);
    setcnt(17'h0_0002);
    paf_reading_src_i.send(24'h00_0008);
    paf_reading_src_i.send(24'h00_0010);
    paf_reading_src_i.send(24'h00_0018);
    await(3);
    chk(got[0], 32'h0000_0008);
    chk(got[1], 32'h0000_000C);
    chk(got[2], 32'h0000_0014);
    misc_pulses(2'h2);
    got.delete();
    chk(fill, 32'h0000_0000);
    paf_reading_src_i.send(24'h00_0064);
    await(1);
    chk(got[0], 32'h0000_0064);
    $display("test moving done");
  endtask : t_moving
  // Quick mode at the shortest window, with the result side stalled.
  task automatic t_quick();
    aper <= paf_pkg::MIN_APER_US;
    cfg(1'b1, 1'b1, 1'b0);
    setcnt(17'h0_0009);
    chk(eff, 32'h0000_0001);
    chk(qo, 32'h0000_0001);
    chk(so, 32'h0000_0001);
    chk(mt, 32'h0000_0008);
    cfg(1'b1, 1'b0, 1'b0);
    res_ready <= 1'b0;
    fork
      for (int i = 1; i <= 6; i++) paf_reading_src_i.send(i[23:0]);
    join_none
    repeat (30) @(posedge clk_sys_in);
    chk(rd_ready, 32'h0000_0000);
    res_ready <= 1'b1;
    await(6);
    for (int i = 1; i <= 6; i++) chk(got[i-1], i);
    $display("test quick done");
  endtask : t_quick
  // Automatic count per digits target, its freeze, the noise criterion, the enable.
  task automatic t_auto();
    dig <= 3'h2;
    cfg(1'b0, 1'b0, 1'b0);
    misc_pulses(2'h1);
    chk(eff, 32'h0000_0004);
    dig <= 3'h4;
    cfg(1'b0, 1'b0, 1'b0);
    chk(eff, 32'h0000_0040);
    misc_pulses(2'h0);
    dig <= 3'h2;
    cfg(1'b0, 1'b0, 1'b0);
    chk(eff, 32'h0000_0040);
    crit <= 1'b1;
    cfg(1'b0, 1'b0, 1'b0);
    misc_pulses(2'h1);
    chk(eff, 32'h0000_0004);
    aen <= 1'b0;
    cfg(1'b0, 1'b0, 1'b0);
    chk(eff, 32'h0000_0001);
    $display("test auto done");
  endtask : t_auto

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    t_reset();
    t_repeat();
    t_moving();
    t_quick();
    t_auto();
    finish_test();
  end
  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial begin
    #400000;
    bad_count++;
    finish_test();
  end
endmodule : power_averaging_filter_tb
`default_nettype wire
